// ---- core/rsfp_params.svh ----
`ifndef RSFP_PARAMS_SVH
`define RSFP_PARAMS_SVH

// Command codes
`define RSFP_CMD_PAGE      8'h00
`define RSFP_CMD_RAIL_ST   8'hB9
`define RSFP_CMD_FPIN      8'hD0
`define RSFP_CMD_FRESP     8'hF4

// Command port address fields
`define RSFP_CMD_LSB       6
`define RSFP_IDX_W         6

// Byte counts and payload positions
`define RSFP_RS_COUNT      8'h01
`define RSFP_FP_COUNT      8'h21
`define RSFP_FP_OTHER_IDX  6'h21
`define RSFP_FP_LAST_MASK  6'h20
`define RSFP_FP_PIN_LSB    3
`define RSFP_FP_RSV_BIT    2

// Reset values
`define RSFP_PAGE_RST      8'h00
`define RSFP_OTHER_RST     8'h00

// Turn-on and turn-off delay counts in clock cycles
`define RSFP_TON_CYC       16'h0004
`define RSFP_TOFF_CYC      16'h0004

// Encoded rail states
`define RSFP_ST_INACTIVE   8'h01
`define RSFP_ST_WAIT_ON    8'h02
`define RSFP_ST_ON_DLY     8'h03
`define RSFP_ST_RISING     8'h04
`define RSFP_ST_IN_A       8'h05
`define RSFP_ST_WAIT_OFF   8'h06
`define RSFP_ST_OFF_DLY    8'h07
`define RSFP_ST_FALLING    8'h08

`endif

// ---- core/rsfp_pkg.sv ----
`include "rsfp_params.svh"

package rsfp_pkg;

    typedef enum logic [2:0]
    {
        RSFP_INACTIVE,
        RSFP_WAIT_ON_DEP,
        RSFP_ON_DELAY,
        RSFP_RISING,
        RSFP_IN_A,
        RSFP_WAIT_OFF_DEP,
        RSFP_OFF_DELAY,
        RSFP_FALLING
    } rsfp_rail_st_t;

    // Reported byte for each rail state
    function automatic logic [7:0] rsfp_code(input rsfp_rail_st_t st);
        logic [7:0] c;
        c = `RSFP_ST_INACTIVE;
        unique case (st)
            RSFP_INACTIVE:     c = `RSFP_ST_INACTIVE;
            RSFP_WAIT_ON_DEP:  c = `RSFP_ST_WAIT_ON;
            RSFP_ON_DELAY:     c = `RSFP_ST_ON_DLY;
            RSFP_RISING:       c = `RSFP_ST_RISING;
            RSFP_IN_A:         c = `RSFP_ST_IN_A;
            RSFP_WAIT_OFF_DEP: c = `RSFP_ST_WAIT_OFF;
            RSFP_OFF_DELAY:    c = `RSFP_ST_OFF_DLY;
            RSFP_FALLING:      c = `RSFP_ST_FALLING;
        endcase
        return c;
    endfunction

endpackage

// ---- core/rsfp_fmap_if.sv ----
`timescale 1ns/1ps

interface rsfp_fmap_if #(
    parameter int PINS = 4
);
    logic [PINS-1:0][31:0] mask;
    logic [31:0]           fault;
    logic [PINS-1:0]       pin;

    modport owner  (output mask, output fault, input pin);
    modport mapper (input mask, input fault, output pin);
endinterface

// ---- core/rsfp_fmap.sv ----
`timescale 1ns/1ps

module rsfp_fmap
    import rsfp_pkg::*;
#(
    parameter int PINS = 4
)(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // Masks, faults and pins
    rsfp_fmap_if.mapper fm
);
    typedef struct packed
    {
        logic [PINS-1:0] pin;
    } rsfp_fmap_reg_t;

    rsfp_fmap_reg_t r;
    rsfp_fmap_reg_t next_r;

    // Pin asserts while any selected rail has a fault
    always_comb
    begin
        next_r = r;
        for (int p = 0; p < PINS; p++)
        begin
            next_r.pin[p] = |(fm.mask[p] & fm.fault);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign fm.pin = r.pin;
endmodule

// ---- core/rsfp_rail.sv ----
`timescale 1ns/1ps
`include "rsfp_params.svh"

module rsfp_rail
    import rsfp_pkg::*;
#(
    parameter logic [15:0] TON_CYC  = `RSFP_TON_CYC,
    parameter logic [15:0] TOFF_CYC = `RSFP_TOFF_CYC
)(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Rail conditions
    input  wire logic       i_on_req,
    input  wire logic       i_on_dep_ok,
    input  wire logic       i_off_dep_ok,
    input  wire logic       i_pgood,
    input  wire logic       i_pg_zero,
    input  wire logic       i_toff_unlim,
    input  wire logic       i_fault,
    input  wire logic       i_retry,
    input  wire logic       i_ramp_done,
    // Rail outputs
    output logic            o_en,
    output logic [7:0]      o_code
);
    typedef struct packed
    {
        rsfp_rail_st_t st;
        logic [15:0]   cnt;
        logic          en;
        logic [7:0]    code;
    } rsfp_rail_reg_t;

    rsfp_rail_reg_t r;
    rsfp_rail_reg_t next_r;

    always_comb
    begin
        next_r = r;
        if (i_fault && r.en)
        begin
            next_r.en = 1'b0;
            next_r.st = (!i_toff_unlim && !i_retry) ? RSFP_FALLING : RSFP_INACTIVE;
        end
        else
        begin
            unique case (r.st)
                RSFP_INACTIVE:
                    if (i_on_req && !i_fault)
                        next_r.st = RSFP_WAIT_ON_DEP;
                RSFP_WAIT_ON_DEP:
                    if (i_fault || !i_on_req)
                        next_r.st = RSFP_INACTIVE;
                    else if (i_on_dep_ok)
                    begin
                        next_r.st  = RSFP_ON_DELAY;
                        next_r.cnt = TON_CYC;
                    end
                RSFP_ON_DELAY:
                    if (i_fault || !i_on_req)
                        next_r.st = RSFP_INACTIVE;
                    else if (r.cnt == 16'h0000)
                    begin
                        next_r.st = RSFP_RISING;
                        next_r.en = 1'b1;
                    end
                    else
                        next_r.cnt = r.cnt - 16'h0001;
                RSFP_RISING:
                    if (!i_on_req)
                        next_r.st = RSFP_WAIT_OFF_DEP;
                    else if (i_pgood && !i_pg_zero)
                        next_r.st = RSFP_IN_A;
                RSFP_IN_A:
                    if (!i_on_req)
                        next_r.st = RSFP_WAIT_OFF_DEP;
                RSFP_WAIT_OFF_DEP:
                    if (i_off_dep_ok)
                    begin
                        next_r.st  = RSFP_OFF_DELAY;
                        next_r.cnt = TOFF_CYC;
                    end
                RSFP_OFF_DELAY:
                    if (r.cnt == 16'h0000)
                    begin
                        next_r.en = 1'b0;
                        next_r.st = i_toff_unlim ? RSFP_INACTIVE : RSFP_FALLING;
                    end
                    else
                        next_r.cnt = r.cnt - 16'h0001;
                RSFP_FALLING:
                    if (i_ramp_done)
                        next_r.st = RSFP_INACTIVE;
            endcase
        end
        next_r.code = rsfp_code(next_r.st);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '{st: RSFP_INACTIVE, cnt: 16'h0000, en: 1'b0, code: `RSFP_ST_INACTIVE};
        else
            r <= next_r;
    end

    assign o_en   = r.en;
    assign o_code = r.code;
endmodule

// ---- core/rsfp_top.sv ----
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "rsfp_params.svh"

// Summary of operation
// - State read returns count 1, one byte
// - Inactive: no on condition, faulted, resequencing
// - Wait-on state holds until dependencies met
// - On-delay state counts before enable asserts
// - Rising until power good; 0 V stays
// - In_a holds despite voltage dip, until fault or on request drops
// - Wait-off state holds until off dependencies met
// - Off-delay state counts before enable drops
// - Falling only when off limit not unlimited
// - Fault turn-off under retry reports inactive
// - Pin map command: 33 bytes, last other
// - Eight bytes per pin: LSB-first mask, reserved
// - Pin driven from faults of masked rails
// - At most four pins; designation elsewhere
// - State read is paged by current page
// - Mask bit n selects page n
module rsfp_top
    import rsfp_pkg::*;
#(
    parameter int          PAGES    = 32,
    parameter int          PINS     = 4,
    parameter logic [15:0] TON_CYC  = `RSFP_TON_CYC,
    parameter logic [15:0] TOFF_CYC = `RSFP_TOFF_CYC
)(
    // Clock and reset
    input  wire logic             I_CLK,
    input  wire logic             I_RST,
    // Command port
    input  wire logic [13:0]      I_ADDR,
    input  wire logic [7:0]       I_WDATA,
    input  wire logic             I_WR,
    input  wire logic             I_RD,
    output logic      [7:0]       O_RDATA,
    // Rail conditions
    input  wire logic [PAGES-1:0] I_ON_REQ,
    input  wire logic [PAGES-1:0] I_ON_DEP_OK,
    input  wire logic [PAGES-1:0] I_OFF_DEP_OK,
    input  wire logic [PAGES-1:0] I_PGOOD,
    input  wire logic [PAGES-1:0] I_PG_ZERO,
    input  wire logic [PAGES-1:0] I_TOFF_UNLIM,
    input  wire logic [PAGES-1:0] I_FAULT,
    input  wire logic [PAGES-1:0] I_RETRY,
    input  wire logic [PAGES-1:0] I_RAMP_DONE,
    // Rail enables and fault pins
    output logic      [PAGES-1:0] O_RAIL_EN,
    output logic      [PINS-1:0]  O_FAULT_PIN
);
    typedef struct packed
    {
        logic [7:0]            page;
        logic [PINS-1:0][31:0] mask;
        logic [7:0]            other;
        logic [7:0]            rdata;
    } rsfp_top_reg_t;

    rsfp_top_reg_t              st;
    rsfp_top_reg_t              next_st;
    logic [PAGES-1:0][7:0]      rail_code;
    logic [7:0]                 cmd;
    logic [5:0]                 idx;
    logic [5:0]                 pidx;
    logic [1:0]                 pin;
    logic [1:0]                 mbyte;
    logic [7:0]                 sel_code;

    rsfp_fmap_if #(.PINS(PINS)) fm ();

    // Payload byte holds part of an implemented pin's page mask
    function automatic logic mask_slot(input logic [5:0] i);
        logic [5:0] p;
        p = i - 6'h01;
        return (i != 6'h00) && (i <= `RSFP_FP_LAST_MASK) && !p[`RSFP_FP_RSV_BIT]
               && (32'(p[4:3]) < PINS);
    endfunction

    assign cmd   = I_ADDR[13:`RSFP_CMD_LSB];
    assign idx   = I_ADDR[`RSFP_IDX_W-1:0];
    assign pidx  = idx - 6'h01;
    assign pin   = pidx[4:`RSFP_FP_PIN_LSB];
    assign mbyte = pidx[1:0];
    assign sel_code = (32'(st.page) < PAGES) ? rail_code[st.page[4:0]] : 8'h00;

    // Per-rail sequencing
    for (genvar g = 0; g < PAGES; g++)
    begin : g_rail
        rsfp_rail #(
            .TON_CYC  (TON_CYC),
            .TOFF_CYC (TOFF_CYC)
        ) u_rail (
            .i_clk        (I_CLK),
            .i_rst        (I_RST),
            .i_on_req     (I_ON_REQ[g]),
            .i_on_dep_ok  (I_ON_DEP_OK[g]),
            .i_off_dep_ok (I_OFF_DEP_OK[g]),
            .i_pgood      (I_PGOOD[g]),
            .i_pg_zero    (I_PG_ZERO[g]),
            .i_toff_unlim (I_TOFF_UNLIM[g]),
            .i_fault      (I_FAULT[g]),
            .i_retry      (I_RETRY[g]),
            .i_ramp_done  (I_RAMP_DONE[g]),
            .o_en         (O_RAIL_EN[g]),
            .o_code       (rail_code[g])
        );
    end

    // Fault pin mapping
    assign fm.mask  = st.mask;
    assign fm.fault = 32'(I_FAULT);

    rsfp_fmap #(
        .PINS (PINS)
    ) u_fmap (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .fm    (fm)
    );

    assign O_FAULT_PIN = fm.pin;

    // Command decode
    always_comb
    begin
        next_st       = st;
        next_st.rdata = 8'h00;
        if (I_RD)
        begin
            unique case (cmd)
                `RSFP_CMD_PAGE:
                    if (idx == 6'h00)
                        next_st.rdata = st.page;
                `RSFP_CMD_RAIL_ST:
                    if (idx == 6'h00)
                        next_st.rdata = `RSFP_RS_COUNT;
                    else if (idx == 6'h01)
                        next_st.rdata = sel_code;
                `RSFP_CMD_FPIN:
                    if (idx == 6'h00)
                        next_st.rdata = `RSFP_FP_COUNT;
                    else if (mask_slot(idx))
                        next_st.rdata = st.mask[pin][{mbyte, 3'b000} +: 8];
                    else if (idx == `RSFP_FP_OTHER_IDX)
                        next_st.rdata = st.other;
                default:
                    next_st.rdata = 8'h00;
            endcase
        end
        if (I_WR)
        begin
            unique case (cmd)
                `RSFP_CMD_PAGE:
                    if (idx == 6'h00)
                        next_st.page = I_WDATA;
                `RSFP_CMD_FPIN:
                    if (mask_slot(idx))
                        next_st.mask[pin][{mbyte, 3'b000} +: 8] = I_WDATA;
                    else if (idx == `RSFP_FP_OTHER_IDX)
                        next_st.other = I_WDATA;
                default:
                    next_st.page = st.page;
            endcase
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            st <= '{page: `RSFP_PAGE_RST, mask: '0, other: `RSFP_OTHER_RST, rdata: 8'h00};
        else
            st <= next_st;
    end

    assign O_RDATA = st.rdata;

    // Checks on rail 0 and the command port
    logic [7:0] r0_code;
    logic       r0_en;
    logic       r0_fall;
    logic       pin0_hit;
    logic       rd_rs;
    logic       rd_fp;
    logic       wr_fp;

    assign r0_code  = rail_code[0];
    assign r0_en    = O_RAIL_EN[0];
    assign r0_fall  = (r0_code == `RSFP_ST_FALLING);
    assign pin0_hit = |(st.mask[0] & 32'(I_FAULT));
    assign rd_rs    = I_RD && (cmd == `RSFP_CMD_RAIL_ST);
    assign rd_fp    = I_RD && (cmd == `RSFP_CMD_FPIN);
    assign wr_fp    = I_WR && (cmd == `RSFP_CMD_FPIN);

    property p_rs_count;
        @(posedge I_CLK) disable iff (I_RST)
        rd_rs && (idx == 6'h00) |=> (O_RDATA == `RSFP_RS_COUNT);
    endproperty
    a_rs_count: assert property (p_rs_count) else $error("State read count is not 1");

    property p_rs_code;
        @(posedge I_CLK) disable iff (I_RST)
        rd_rs && (idx == 6'h01) |=> (O_RDATA == $past(sel_code)) ##1 (O_RDATA == 8'h00 || $past(I_RD));
    endproperty
    a_rs_code: assert property (p_rs_code) else $error("State read not of current page");

    property p_fp_count;
        @(posedge I_CLK) disable iff (I_RST)
        rd_fp && (idx == 6'h00) |=> (O_RDATA == `RSFP_FP_COUNT);
    endproperty
    a_fp_count: assert property (p_fp_count) else $error("Pin map count is not 33");

    property p_fp_back;
        @(posedge I_CLK) disable iff (I_RST)
        wr_fp && (mask_slot(idx) || idx == `RSFP_FP_OTHER_IDX)
        ##1 (I_RD && I_ADDR == $past(I_ADDR)) |=> (O_RDATA == $past(I_WDATA, 2));
    endproperty
    a_fp_back: assert property (p_fp_back) else $error("Pin map byte not returned");

    property p_fp_rsv;
        @(posedge I_CLK) disable iff (I_RST)
        rd_fp && (idx != 6'h00) && (idx <= `RSFP_FP_LAST_MASK) && pidx[`RSFP_FP_RSV_BIT]
        |=> (O_RDATA == 8'h00);
    endproperty
    a_fp_rsv: assert property (p_fp_rsv) else $error("Reserved byte not zero");

    property p_pin;
        @(posedge I_CLK) disable iff (I_RST)
        ##1 1'b1 |-> (O_FAULT_PIN[0] == $past(pin0_hit));
    endproperty
    a_pin: assert property (p_pin) else $error("Fault pin disagrees with masked faults");

    property p_wait_on;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_WAIT_ON) && I_ON_REQ[0] && !I_FAULT[0] && !I_ON_DEP_OK[0]
        |-> !r0_en ##1 (r0_code == `RSFP_ST_WAIT_ON);
    endproperty
    a_wait_on: assert property (p_wait_on) else $error("Wait-on state left early");

    property p_on_dly;
        @(posedge I_CLK) disable iff (I_RST)
        $rose(r0_code == `RSFP_ST_ON_DLY) && I_ON_REQ[0] && !I_FAULT[0]
        |-> !r0_en;
    endproperty
    a_on_dly: assert property (p_on_dly) else $error("Enable high in on-delay");

    property p_rise;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_RISING) && I_PG_ZERO[0] && I_ON_REQ[0] && !I_FAULT[0]
        |-> r0_en ##1 (r0_code == `RSFP_ST_RISING);
    endproperty
    a_rise: assert property (p_rise) else $error("Rising left with 0 V threshold");

    property p_in_a;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_IN_A) && I_ON_REQ[0] && !I_FAULT[0]
        |=> (r0_code == `RSFP_ST_IN_A) && r0_en;
    endproperty
    a_in_a: assert property (p_in_a) else $error("In_a left without cause");

    property p_wait_off;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_WAIT_OFF) && !I_FAULT[0] && !I_OFF_DEP_OK[0]
        |-> r0_en ##1 (r0_code == `RSFP_ST_WAIT_OFF);
    endproperty
    a_wait_off: assert property (p_wait_off) else $error("Wait-off state left early");

    property p_off_dly;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_OFF_DLY) |-> r0_en;
    endproperty
    a_off_dly: assert property (p_off_dly) else $error("Enable low in off-delay");

    property p_fall;
        @(posedge I_CLK) disable iff (I_RST)
        $rose(r0_fall) |-> !$past(I_TOFF_UNLIM[0]) && !r0_en;
    endproperty
    a_fall: assert property (p_fall) else $error("Falling with unlimited off limit");

    property p_retry;
        @(posedge I_CLK) disable iff (I_RST)
        r0_en && I_FAULT[0] && I_RETRY[0] |=> (r0_code == `RSFP_ST_INACTIVE) && !r0_en;
    endproperty
    a_retry: assert property (p_retry) else $error("Retry fault not reported inactive");

    property p_fault_early;
        @(posedge I_CLK) disable iff (I_RST)
        I_FAULT[0] && ((r0_code == `RSFP_ST_WAIT_ON) || (r0_code == `RSFP_ST_ON_DLY))
        |=> (r0_code == `RSFP_ST_INACTIVE);
    endproperty
    a_fault_early: assert property (p_fault_early) else $error("Fault did not idle rail");

    property p_order;
        @(posedge I_CLK) disable iff (I_RST)
        (r0_code == `RSFP_ST_INACTIVE) |=>
        (r0_code == `RSFP_ST_INACTIVE) || (r0_code == `RSFP_ST_WAIT_ON);
    endproperty
    a_order: assert property (p_order) else $error("Inactive left out of order");

    c_in_a: cover property (@(posedge I_CLK) disable iff (I_RST) $rose(r0_code == `RSFP_ST_IN_A));
    c_fall: cover property (@(posedge I_CLK) disable iff (I_RST) $rose(r0_fall));
    c_pin:  cover property (@(posedge I_CLK) disable iff (I_RST) $rose(O_FAULT_PIN[0]));
    c_read: cover property (@(posedge I_CLK) disable iff (I_RST) rd_rs ##1 rd_fp);
endmodule

// ---- bench/rsfp_host.sv ----
`timescale 1ns/1ps
`include "rsfp_params.svh"

module rsfp_host (
    // Clock and read data
    input  wire logic        i_clk,
    input  wire logic [7:0]  i_rdata,
    // Command port
    output logic      [13:0] o_addr,
    output logic      [7:0]  o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial
    begin
        o_addr  = 14'h0000;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end

    // One write cycle
    task automatic wr(input logic [7:0] c, input logic [5:0] i, input logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= {c, i};
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
    endtask

    // One read cycle, data taken in the following cycle
    task automatic rd(input logic [7:0] c, input logic [5:0] i, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= {c, i};
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // Write then read back with no gap between the strobes
    task automatic wr_rd(input logic [7:0] c, input logic [5:0] i, input logic [7:0] w, output logic [7:0] d);
        @(posedge i_clk);
        o_addr  <= {c, i};
        o_wdata <= w;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_rd    <= 1'b1;
        @(posedge i_clk);
        o_rd    <= 1'b0;
        #1;
        d = i_rdata;
    endtask

    // Mask least significant byte first, then four zero reserved bytes
    task automatic set_mask(input logic [1:0] p, input logic [31:0] m);
        for (int b = 0; b < 8; b++)
            wr(`RSFP_CMD_FPIN, 6'(8 * p + b + 1), (b < 4) ? m[8 * b +: 8] : 8'h00);
        wr(`RSFP_CMD_FRESP, 6'(p + 1), 8'h00);
    endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "rsfp_params.svh"

module testbench;
    typedef struct packed
    {
        logic [31:0] flt;
        logic [3:0]  pins;
    } rsfp_row_t;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [13:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  d;
    logic        wr;
    logic        rd;
    logic [31:0] on_req = '0;
    logic [31:0] on_dep = '0;
    logic [31:0] off_dep = '0;
    logic [31:0] pgood = '0;
    logic [31:0] pg_zero = '0;
    logic [31:0] unlim = '0;
    logic [31:0] fault = '0;
    logic [31:0] retry = '0;
    logic [31:0] ramp = '0;
    logic [31:0] en;
    logic [3:0]  fpin;
    int          error_cnt = 0;
    int          comparisons = 0;
    rsfp_row_t   rows [7] = '{
        '{32'h0000_0000, 4'h0}, '{32'h0000_0001, 4'h1}, '{32'h8000_0000, 4'h2},
        '{32'h0001_0000, 4'h4}, '{32'h0000_0100, 4'h8}, '{32'h7f00_fe02, 4'h0},
        '{32'hffff_ffff, 4'hf}};

    always #2 clk = ~clk;

    rsfp_host host (
        .i_clk   (clk),
        .i_rdata (rdata),
        .o_addr  (addr),
        .o_wdata (wdata),
        .o_wr    (wr),
        .o_rd    (rd)
    );

    rsfp_top dut (
        .I_CLK        (clk),
        .I_RST        (rst),
        .I_ADDR       (addr),
        .I_WDATA      (wdata),
        .I_WR         (wr),
        .I_RD         (rd),
        .O_RDATA      (rdata),
        .I_ON_REQ     (on_req),
        .I_ON_DEP_OK  (on_dep),
        .I_OFF_DEP_OK (off_dep),
        .I_PGOOD      (pgood),
        .I_PG_ZERO    (pg_zero),
        .I_TOFF_UNLIM (unlim),
        .I_FAULT      (fault),
        .I_RETRY      (retry),
        .I_RAMP_DONE  (ramp),
        .O_RAIL_EN    (en),
        .O_FAULT_PIN  (fpin)
    );

    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Select a page and read its state byte
    task automatic st(input logic [7:0] pg, input logic [7:0] exp);
        host.wr(`RSFP_CMD_PAGE, 6'h00, pg);
        host.rd(`RSFP_CMD_RAIL_ST, 6'h01, d);
        chk(d, exp);
    endtask

    // Bounded wait for a rail enable level
    task automatic wait_en(input int r, input logic v);
        int n;
        n = 0;
        while (en[r] !== v && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 40)
        begin
            error_cnt++;
            $display("[FAIL] %0t enable wait timed out", $time);
            test_done();
        end
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(en, 32'h0000_0000);
        chk(fpin, 4'h0);
        host.rd(`RSFP_CMD_RAIL_ST, 6'h00, d);
        chk(d, `RSFP_RS_COUNT);
        st(8'h00, `RSFP_ST_INACTIVE);
        host.rd(`RSFP_CMD_FPIN, 6'h00, d);
        chk(d, `RSFP_FP_COUNT);
        host.set_mask(2'd0, 32'h0000_0001);
        host.set_mask(2'd1, 32'h8000_0000);
        host.set_mask(2'd2, 32'h00ff_0000);
        host.set_mask(2'd3, 32'h0000_0100);
        host.wr(`RSFP_CMD_FPIN, `RSFP_FP_OTHER_IDX, 8'h5a);
        for (int b = 0; b < 5; b++)
        begin
            host.rd(`RSFP_CMD_FPIN, 6'(9 + b), d);
            chk(d, (b == 3) ? 8'h80 : 8'h00);
        end
        host.rd(`RSFP_CMD_FPIN, `RSFP_FP_OTHER_IDX, d);
        chk(d, 8'h5a);
        host.wr_rd(`RSFP_CMD_FPIN, 6'h11, 8'h3c, d);
        chk(d, 8'h3c);
        host.rd(`RSFP_CMD_FRESP, 6'h01, d);
        chk(d, 8'h00);
        foreach (rows[i])
        begin
            @(posedge clk);
            fault <= rows[i].flt;
            repeat (2) @(posedge clk);
            #1;
            chk(fpin, rows[i].pins);
        end
        @(posedge clk);
        fault <= '0;
        on_req[0] <= 1'b1;
        st(8'h00, `RSFP_ST_WAIT_ON);
        @(posedge clk);
        on_dep[0] <= 1'b1;
        st(8'h00, `RSFP_ST_ON_DLY);
        chk(en[0], 1'b0);
        wait_en(0, 1'b1);
        st(8'h00, `RSFP_ST_RISING);
        @(posedge clk);
        pgood[0] <= 1'b1;
        pg_zero[0] <= 1'b1;
        st(8'h00, `RSFP_ST_RISING);
        @(posedge clk);
        pg_zero[0] <= 1'b0;
        st(8'h00, `RSFP_ST_IN_A);
        @(posedge clk);
        pgood[0] <= 1'b0;
        st(8'h00, `RSFP_ST_IN_A);
        @(posedge clk);
        on_req[0] <= 1'b0;
        st(8'h00, `RSFP_ST_WAIT_OFF);
        chk(en[0], 1'b1);
        @(posedge clk);
        off_dep[0] <= 1'b1;
        st(8'h00, `RSFP_ST_OFF_DLY);
        chk(en[0], 1'b1);
        wait_en(0, 1'b0);
        st(8'h00, `RSFP_ST_FALLING);
        @(posedge clk);
        ramp[0] <= 1'b1;
        st(8'h00, `RSFP_ST_INACTIVE);
        @(posedge clk);
        retry <= 32'h0000_0002;
        unlim <= 32'h0000_0008;
        on_req <= 32'h0000_000e;
        on_dep <= 32'h0000_000f;
        off_dep <= 32'h0000_000f;
        wait_en(3, 1'b1);
        @(posedge clk);
        fault <= 32'h0000_0006;
        on_req <= 32'h0000_0006;
        repeat (2) @(posedge clk);
        #1;
        chk(en[2:1], 2'b00);
        wait_en(3, 1'b0);
        st(8'h01, `RSFP_ST_INACTIVE);
        st(8'h02, `RSFP_ST_FALLING);
        st(8'h03, `RSFP_ST_INACTIVE);
        st(8'h28, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        host.rd(`RSFP_CMD_FPIN, 6'h01, d);
        chk(d, 8'h00);
        chk(en, 32'h0000_0000);
        chk(fpin, 4'h0);
        test_done();
    end
endmodule
